// *** src/sfc_pkg.sv ***
// Purpose: Shared constants and types for the serial flash command and status block
// Assumes: Core clock of 250 MHz; status byte layout fixed at 8 bits
// Notes:   Busy cycle counts follow the worst-case array times
package sfc_pkg;

   // Opcodes
   localparam logic [7:0] OP_LATCH_SET     = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR     = 8'h04;
   localparam logic [7:0] OP_STAT_FETCH    = 8'h05;
   localparam logic [7:0] OP_STAT_STORE    = 8'h01;
   localparam logic [7:0] OP_ARR_READ      = 8'h03;
   localparam logic [7:0] OP_QUICK_FETCH   = 8'h0b;
   localparam logic [7:0] OP_PAGE_BURN     = 8'h02;
   localparam logic [7:0] OP_PAGE_CLEAR    = 8'h81;
   localparam logic [7:0] OP_HALF_CLEAR    = 8'hd8;
   localparam logic [7:0] OP_WHOLE_CLEAR   = 8'hc7;
   localparam logic [7:0] OP_LOCK_ENTRY    = 8'hb9;
   localparam logic [7:0] OP_LOCK_RELEASE  = 8'hab;

   // Status byte field positions
   localparam int ST_ARM_BIT  = 7;
   localparam int ST_BPHI_BIT = 3;
   localparam int ST_BPLO_BIT = 2;
   localparam int ST_WEL_BIT  = 1;
   localparam int ST_BUSY_BIT = 0;

   // Reset values
   localparam logic       ST_ARM_RST  = 1'b0;
   localparam logic [1:0] ST_BP_RST   = 2'b00;
   localparam logic       ST_WEL_RST  = 1'b0;
   localparam logic [3:0] PIN_RST     = 4'h9;   // Guard high, select high

   // Block protect levels
   localparam logic [1:0] BP_NONE    = 2'b00;
   localparam logic [1:0] BP_QUARTER = 2'b01;
   localparam logic [1:0] BP_HALF    = 2'b10;
   localparam logic [1:0] BP_ALL     = 2'b11;

   // Array cycle times and derived counts
   localparam int unsigned CLK_MHZ    = 250;
   localparam int unsigned T_PP_MS    = 10;
   localparam int unsigned T_PE_MS    = 6;
   localparam real         T_SE_S     = 0.4;
   localparam real         T_BE_S     = 0.8;
   localparam int unsigned T_STORE_US = 1;
   localparam int unsigned PP_CYC     = T_PP_MS * CLK_MHZ * 1000;
   localparam int unsigned PE_CYC     = T_PE_MS * CLK_MHZ * 1000;
   localparam int unsigned SE_CYC     = int'($rtoi(T_SE_S * CLK_MHZ * 1.0e6));
   localparam int unsigned BE_CYC     = int'($rtoi(T_BE_S * CLK_MHZ * 1.0e6));
   localparam int unsigned STORE_CYC  = T_STORE_US * CLK_MHZ;
   localparam int          BUSY_W     = 28;

   // Array operation kinds
   typedef enum logic [2:0] {
      OPK_BURN  = 3'b000,
      OPK_PAGE  = 3'b001,
      OPK_HALF  = 3'b010,
      OPK_WHOLE = 3'b011,
      OPK_STORE = 3'b100
   } sfc_opk_t;

   // Link states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_OPC   = 3'b001,
      ST_ADDR  = 3'b010,
      ST_DATA  = 3'b011,
      ST_STAT  = 3'b100,
      ST_HOLDZ = 3'b101,
      ST_IGN   = 3'b110
   } sfc_state_t;

endpackage : sfc_pkg

// *** src/sfc_pin_if.sv ***
// Purpose: Carries synchronised link levels and edges from the pin stage to the core
// Assumes: All signals are on mclk
// Notes:   Edge strobes are one mclk cycle wide
`timescale 1ns/100ps
interface sfc_pin_if;
   logic sel;
   logic sel_fall;
   logic sel_rise;
   logic sck_rise;
   logic sck_fall;
   logic si;
   logic guard_n;

   modport front (output sel, sel_fall, sel_rise, sck_rise, sck_fall, si, guard_n);
   modport core  (input  sel, sel_fall, sel_rise, sck_rise, sck_fall, si, guard_n);
endinterface : sfc_pin_if

// *** src/sfc_pins.sv ***
// Purpose: Two-stage synchronisers and edge finders for the serial link pins
// Assumes: Link clock slow against mclk (several mclk per half period)
// Notes:   All four pins share the same delay so their relation is kept
`timescale 1ns/100ps
module sfc_pins (
   input  wire logic   mclk,
   input  wire logic   rst,
   input  wire logic   select_n,
   input  wire logic   sck,
   input  wire logic   si,
   input  wire logic   guard_pin_n,
   sfc_pin_if.front    pin
);
   logic [3:0] raw_w;
   logic [3:0] sync_w;
   logic       sck_d_r;
   logic       seln_d_r;

   assign raw_w = {guard_pin_n, si, sck, select_n};

   // Two flip-flops per pin
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         logic meta_r;
         logic stab_r;
         always_ff @(posedge mclk) begin
            if (rst) begin
               meta_r <= sfc_pkg::PIN_RST[g];
               stab_r <= sfc_pkg::PIN_RST[g];
            end else begin
               meta_r <= raw_w[g];
               stab_r <= meta_r;
            end
         end
         assign sync_w[g] = stab_r;
      end
   endgenerate

   // Delayed copies for edge finding
   always_ff @(posedge mclk) begin
      if (rst) begin
         sck_d_r  <= 1'b0;
         seln_d_r <= 1'b1;
      end else begin
         sck_d_r  <= sync_w[1];
         seln_d_r <= sync_w[0];
      end
   end

   // Levels and edges toward the core
   assign pin.sel      = ~sync_w[0];
   assign pin.sel_fall = seln_d_r & ~sync_w[0];
   assign pin.sel_rise = ~seln_d_r & sync_w[0];
   assign pin.sck_rise = ~sck_d_r & sync_w[1];
   assign pin.sck_fall = sck_d_r & ~sync_w[1];
   assign pin.si       = sync_w[2];
   assign pin.guard_n  = sync_w[3];
endmodule : sfc_pins

// *** src/sfc_flash_cmd.sv ***
// Purpose: Opcode decoder, status byte and write protection of a serial flash
// Assumes: Link pins asynchronous to mclk; array engine sits outside
// Notes:   Array read data and identification return are handled elsewhere
// Summary of operation
// - First byte after select goes to an 8-bit opcode register and is decoded.
// - Opcodes, addresses and data move most significant bit first.
// - Latch-set opcode sets the write latch; latch-clear opcode clears it.
// - Status-fetch opcode reads the status byte; status-store opcode writes it.
// - 03 is array read, 0b fast read, 02 page program.
// - 81 page erase, d8 sector erase, c7 whole array erase.
// - b9 enters lock mode; ab releases it, optionally with three dummy bytes.
// - Status holds arm bit7, protect bits 3 and 2, latch bit1, busy bit0.
// - Busy reads 1 during program or erase, never written by software.
// - Latch bit shows the write enable latch.
// - During an internal write cycle busy and latch both read 1.
// - After status-fetch, input ignored and status shifted out bit 7 first.
// - Write latch is clear after power-up.
// - With the latch clear, array and status writes are refused.
// - Latch-clear works regardless of guard pin; only latch-set re-enables.
// - Output stays high impedance during latch-set and latch-clear.
// - Protect bits guard nothing, top quarter, top half or the whole array.
// - Program or erase targeting a guarded segment leaves the array untouched.
// - Guard pin low with arm bit set blocks status writes.
// - Status-store accepted only with latch set and guard high or arm clear.
// - Arm bit cannot clear while guard pin is low.
// - Status write is opcode then one byte setting arm and protect bits.
// - Unknown opcode: ignore input, output high impedance until next select.
// - While busy, every opcode except status-fetch is ignored.
// - Write latch clears itself when the internal write cycle ends.
// - Sample input on rising clock, drive output after falling, only selected.
`timescale 1ns/100ps
module sfc_flash_cmd #(
   parameter int unsigned PP_CYCLES    = sfc_pkg::PP_CYC,
   parameter int unsigned PE_CYCLES    = sfc_pkg::PE_CYC,
   parameter int unsigned SE_CYCLES    = sfc_pkg::SE_CYC,
   parameter int unsigned BE_CYCLES    = sfc_pkg::BE_CYC,
   parameter int unsigned STORE_CYCLES = sfc_pkg::STORE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        select_n,
   input  wire logic        sck,
   input  wire logic        si,
   input  wire logic        guard_pin_n,
   output logic             so,
   output logic             so_oe,
   output logic             op_start,
   output logic [2:0]       op_kind,
   output logic [15:0]      op_addr,
   output logic [7:0]       prog_data,
   output logic             prog_vld,
   output logic [7:0]       status_byte
);
   sfc_pin_if pin ();

   sfc_pins u_pins (
      .mclk        (mclk),
      .rst         (rst),
      .select_n    (select_n),
      .sck         (sck),
      .si          (si),
      .guard_pin_n (guard_pin_n),
      .pin         (pin)
   );

   sfc_pkg::sfc_state_t           st_r;
   sfc_pkg::sfc_state_t           st_nxt;
   sfc_pkg::sfc_state_t           opc_nxt_w;
   logic [2:0]                    bcnt_r;
   logic [7:0]                    shift_r;
   logic [7:0]                    op_r;
   logic [1:0]                    acnt_r;
   logic [15:0]                   addr_r;
   logic [7:0]                    data_r;
   logic                          got_byte_r;
   logic                          extra_r;
   logic [7:0]                    out_shift_r;
   logic [2:0]                    ocnt_r;
   logic                          so_r;
   logic                          so_oe_r;
   logic                          wel_r;
   logic                          arm_r;
   logic [1:0]                    bp_r;
   logic                          busy_r;
   logic                          lock_r;
   logic [sfc_pkg::BUSY_W-1:0]    busy_cnt_r;
   logic [sfc_pkg::BUSY_W-1:0]    load_cnt_w;
   logic                          op_start_r;
   sfc_pkg::sfc_opk_t             op_kind_r;
   sfc_pkg::sfc_opk_t             kind_w;
   logic [15:0]                   op_addr_r;
   logic [7:0]                    prog_data_r;
   logic                          prog_vld_r;
   logic [7:0]                    byte_w;
   logic [7:0]                    stat_w;
   logic                          byte_done_w;
   logic                          exec_w;
   logic                          hold_ok_w;
   logic                          set_go_w;
   logic                          clr_go_w;
   logic                          lock_go_w;
   logic                          rel_go_w;
   logic                          guard_ok_w;
   logic                          store_go_w;
   logic                          arr_req_w;
   logic                          arr_go_w;
   logic                          prot_hit_w;
   logic                          done_w;
   logic                          start_w;

   // Opcode decode into the next link state
   function automatic sfc_pkg::sfc_state_t dec_op(input logic [7:0] op);
      unique case (op)
         sfc_pkg::OP_STAT_FETCH:  dec_op = sfc_pkg::ST_STAT;
         sfc_pkg::OP_STAT_STORE:  dec_op = sfc_pkg::ST_DATA;
         sfc_pkg::OP_ARR_READ,
         sfc_pkg::OP_QUICK_FETCH,
         sfc_pkg::OP_PAGE_BURN,
         sfc_pkg::OP_PAGE_CLEAR,
         sfc_pkg::OP_HALF_CLEAR:  dec_op = sfc_pkg::ST_ADDR;
         sfc_pkg::OP_LATCH_SET,
         sfc_pkg::OP_LATCH_CLR,
         sfc_pkg::OP_WHOLE_CLEAR,
         sfc_pkg::OP_LOCK_ENTRY,
         sfc_pkg::OP_LOCK_RELEASE: dec_op = sfc_pkg::ST_HOLDZ;
         default:                 dec_op = sfc_pkg::ST_IGN;
      endcase
   endfunction : dec_op

   assign byte_w      = {shift_r[6:0], pin.si};
   assign byte_done_w = pin.sel & pin.sck_rise & (bcnt_r == 3'd7);

   assign opc_nxt_w = (busy_r && byte_w != sfc_pkg::OP_STAT_FETCH) ? sfc_pkg::ST_IGN :
                      (lock_r && byte_w != sfc_pkg::OP_LOCK_RELEASE) ? sfc_pkg::ST_IGN :
                      dec_op(byte_w);

   assign stat_w = {arm_r, 3'b000, bp_r, wel_r, busy_r};

   assign prot_hit_w = (op_r == sfc_pkg::OP_WHOLE_CLEAR) ? (bp_r != sfc_pkg::BP_NONE) :
                       (op_r == sfc_pkg::OP_HALF_CLEAR) ?
                          (bp_r == sfc_pkg::BP_ALL || (addr_r[15] && bp_r != sfc_pkg::BP_NONE)) :
                       (bp_r == sfc_pkg::BP_ALL) ||
                       (bp_r == sfc_pkg::BP_HALF && addr_r[15]) ||
                       (bp_r == sfc_pkg::BP_QUARTER && addr_r[15:14] == 2'b11);

   // Actions taken at deselect on a byte boundary
   assign exec_w    = pin.sel_rise & (bcnt_r == 3'd0);
   assign hold_ok_w = exec_w & (st_r == sfc_pkg::ST_HOLDZ) & ~extra_r;
   assign set_go_w  = hold_ok_w & (op_r == sfc_pkg::OP_LATCH_SET);
   assign clr_go_w  = hold_ok_w & (op_r == sfc_pkg::OP_LATCH_CLR);
   assign lock_go_w = hold_ok_w & (op_r == sfc_pkg::OP_LOCK_ENTRY);
   assign rel_go_w  = exec_w & (st_r == sfc_pkg::ST_HOLDZ) & (op_r == sfc_pkg::OP_LOCK_RELEASE);
   assign guard_ok_w = pin.guard_n | ~arm_r;
   assign store_go_w = exec_w & (st_r == sfc_pkg::ST_DATA) & (op_r == sfc_pkg::OP_STAT_STORE) &
                       got_byte_r & wel_r & guard_ok_w;
   assign arr_req_w  = exec_w & (((st_r == sfc_pkg::ST_DATA) && (op_r == sfc_pkg::OP_PAGE_BURN) && got_byte_r) ||
                       ((st_r == sfc_pkg::ST_HOLDZ) && !extra_r && (op_r == sfc_pkg::OP_PAGE_CLEAR ||
                        op_r == sfc_pkg::OP_HALF_CLEAR || op_r == sfc_pkg::OP_WHOLE_CLEAR)));
   assign arr_go_w   = arr_req_w & wel_r & ~prot_hit_w;
   assign start_w    = arr_go_w | store_go_w;
   assign done_w     = busy_r & (busy_cnt_r == 28'h0000001);

   // Operation kind and cycle length
   // store, program and erase kinds
   assign kind_w     = store_go_w ? sfc_pkg::OPK_STORE :
                       (op_r == sfc_pkg::OP_PAGE_BURN)  ? sfc_pkg::OPK_BURN :
                       (op_r == sfc_pkg::OP_PAGE_CLEAR) ? sfc_pkg::OPK_PAGE :
                       (op_r == sfc_pkg::OP_HALF_CLEAR) ? sfc_pkg::OPK_HALF : sfc_pkg::OPK_WHOLE;
   assign load_cnt_w = (kind_w == sfc_pkg::OPK_STORE) ? sfc_pkg::BUSY_W'(STORE_CYCLES) :
                       (kind_w == sfc_pkg::OPK_BURN)  ? sfc_pkg::BUSY_W'(PP_CYCLES) :
                       (kind_w == sfc_pkg::OPK_PAGE)  ? sfc_pkg::BUSY_W'(PE_CYCLES) :
                       (kind_w == sfc_pkg::OPK_HALF)  ? sfc_pkg::BUSY_W'(SE_CYCLES) :
                       sfc_pkg::BUSY_W'(BE_CYCLES);

   // Link state sequencing
   always_comb begin
      st_nxt = st_r;
      if (pin.sel_fall) begin
         st_nxt = sfc_pkg::ST_OPC;
      end else if (!pin.sel) begin
         st_nxt = sfc_pkg::ST_IDLE;
      end else if (byte_done_w) begin
         unique case (st_r)
            sfc_pkg::ST_OPC:   st_nxt = opc_nxt_w;
            sfc_pkg::ST_ADDR: begin
               if (acnt_r == 2'd2) begin
                  st_nxt = (op_r == sfc_pkg::OP_PAGE_BURN) ? sfc_pkg::ST_DATA : sfc_pkg::ST_HOLDZ;
               end
            end
            sfc_pkg::ST_IDLE, sfc_pkg::ST_DATA, sfc_pkg::ST_STAT,
            sfc_pkg::ST_HOLDZ, sfc_pkg::ST_IGN: st_nxt = st_r;
            default:           st_nxt = sfc_pkg::ST_IGN;
         endcase
      end
   end

   // Input shifting and byte counting
   always_ff @(posedge mclk) begin
      if (rst || pin.sel_fall) begin
         bcnt_r  <= 3'd0;
         shift_r <= 8'h00;
      end else if (pin.sel && pin.sck_rise) begin
         bcnt_r  <= bcnt_r + 3'd1;
         shift_r <= byte_w;
      end
   end

   // Link state, address byte count and data/extra byte flags
   always_ff @(posedge mclk) begin
      if (rst || pin.sel_fall) begin
         st_r       <= rst ? sfc_pkg::ST_IDLE : st_nxt;
         acnt_r     <= 2'd0;
         got_byte_r <= 1'b0;
         extra_r    <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (byte_done_w) begin
            unique case (st_r)
               sfc_pkg::ST_ADDR: acnt_r <= acnt_r + 2'd1;
               sfc_pkg::ST_DATA: got_byte_r <= 1'b1;
               sfc_pkg::ST_HOLDZ: extra_r <= 1'b1;
               default: acnt_r <= acnt_r;
            endcase
         end
      end
   end

   // Byte registers of the current command
   always_ff @(posedge mclk) begin
      if (rst) begin
         op_r   <= 8'h00;
         addr_r <= 16'h0000;
         data_r <= 8'h00;
      end else if (byte_done_w) begin
         if (st_r == sfc_pkg::ST_OPC) op_r <= byte_w;
         if (st_r == sfc_pkg::ST_ADDR) addr_r <= {addr_r[7:0], byte_w};
         if (st_r == sfc_pkg::ST_DATA && !got_byte_r) data_r <= byte_w;
      end
   end

   // status shift out after falling edges
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_shift_r <= 8'h00;
         ocnt_r      <= 3'd0;
         so_r        <= 1'b0;
      end else if (byte_done_w && st_r == sfc_pkg::ST_OPC) begin
         out_shift_r <= stat_w;
         ocnt_r      <= 3'd0;
      end else if (pin.sel && pin.sck_fall && st_r == sfc_pkg::ST_STAT) begin
         so_r        <= out_shift_r[7];
         ocnt_r      <= ocnt_r + 3'd1;
         out_shift_r <= (ocnt_r == 3'd7) ? stat_w : {out_shift_r[6:0], 1'b0};
      end
   end

   // output enable only in status output
   always_ff @(posedge mclk) begin
      if (rst || st_nxt != sfc_pkg::ST_STAT) begin
         so_oe_r <= 1'b0;
      end else if (pin.sck_fall && st_r == sfc_pkg::ST_STAT) begin
         so_oe_r <= 1'b1;
      end
   end

   // latch, status bits, lock and busy updates
   always_ff @(posedge mclk) begin
      if (rst) begin
         wel_r <= sfc_pkg::ST_WEL_RST;
      end else if (clr_go_w || done_w) begin
         wel_r <= 1'b0;
      end else if (set_go_w) begin
         wel_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         arm_r <= sfc_pkg::ST_ARM_RST;
         bp_r  <= sfc_pkg::ST_BP_RST;
      end else if (store_go_w) begin
         arm_r <= data_r[sfc_pkg::ST_ARM_BIT] | (arm_r & ~pin.guard_n);
         bp_r  <= data_r[sfc_pkg::ST_BPHI_BIT:sfc_pkg::ST_BPLO_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || rel_go_w) begin
         lock_r <= 1'b0;
      end else if (lock_go_w) begin
         lock_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_r     <= 1'b0;
         busy_cnt_r <= '0;
      end else if (start_w) begin
         busy_r     <= 1'b1;
         busy_cnt_r <= load_cnt_w;
      end else if (busy_r) begin
         busy_r     <= ~done_w;
         busy_cnt_r <= busy_cnt_r - 28'h0000001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         op_start_r <= 1'b0;
         op_kind_r  <= sfc_pkg::OPK_BURN;
         op_addr_r  <= 16'h0000;
      end else begin
         op_start_r <= start_w;
         if (start_w) begin
            op_kind_r <= kind_w;
            op_addr_r <= addr_r;
         end
      end
   end

   // Program data bytes toward the page buffer
   always_ff @(posedge mclk) begin
      if (rst) begin
         prog_data_r <= 8'h00;
         prog_vld_r  <= 1'b0;
      end else begin
         prog_vld_r <= byte_done_w & (st_r == sfc_pkg::ST_DATA) & (op_r == sfc_pkg::OP_PAGE_BURN) &
                       wel_r & ~prot_hit_w;
         if (byte_done_w) prog_data_r <= byte_w;
      end
   end

   // Output pins
   assign so          = so_r;
   assign so_oe       = so_oe_r;
   assign op_start    = op_start_r;
   assign op_kind     = op_kind_r;
   assign op_addr     = op_addr_r;
   assign prog_data   = prog_data_r;
   assign prog_vld    = prog_vld_r;
   assign status_byte = stat_w;

   // Checks
   a_stat_zero_bits: assert property (@(posedge mclk) disable iff (rst)
      stat_w[6:4] == 3'b000) else $error("status bits 6..4 not zero");
   a_busy_wel_set: assert property (@(posedge mclk) disable iff (rst)
      busy_r |-> wel_r) else $error("busy without write latch");
   a_done_wel_clear: assert property (@(posedge mclk) disable iff (rst)
      $fell(busy_r) |-> !wel_r) else $error("latch not cleared at cycle end");
   a_arm_locked: assert property (@(posedge mclk) disable iff (rst)
      arm_r && !pin.guard_n |=> arm_r) else $error("arm cleared while guard low");
   a_store_guard: assert property (@(posedge mclk) disable iff (rst)
      $changed(bp_r) |-> $past(wel_r) && $past(guard_ok_w)) else $error("status written unguarded");
   a_busy_ignore: assert property (@(posedge mclk) disable iff (rst)
      byte_done_w && st_r == sfc_pkg::ST_OPC && busy_r && byte_w != sfc_pkg::OP_STAT_FETCH
      |=> st_r == sfc_pkg::ST_IGN) else $error("opcode accepted while busy");
   a_hiz_states: assert property (@(posedge mclk) disable iff (rst)
      st_r inside {sfc_pkg::ST_IDLE, sfc_pkg::ST_IGN, sfc_pkg::ST_HOLDZ} |-> !so_oe_r)
      else $error("output driven outside status read");
   a_prot_block: assert property (@(posedge mclk) disable iff (rst)
      arr_req_w && prot_hit_w |=> !op_start_r ##1 !op_start_r) else $error("protected target launched");
   a_wel_refuse: assert property (@(posedge mclk) disable iff (rst)
      arr_req_w && !wel_r && !busy_r |=> !busy_r) else $error("write accepted without latch");
   a_start_busy: assert property (@(posedge mclk) disable iff (rst)
      arr_go_w |=> busy_r && op_start_r) else $error("busy not raised on launch");
   a_wel_set: assert property (@(posedge mclk) disable iff (rst)
      set_go_w |=> wel_r) else $error("latch not set");
   a_fetch_load: assert property (@(posedge mclk) disable iff (rst)
      byte_done_w && st_r == sfc_pkg::ST_OPC && byte_w == sfc_pkg::OP_STAT_FETCH
      |=> out_shift_r == $past(stat_w)) else $error("status not loaded for fetch");
endmodule : sfc_flash_cmd

// *** dv/sfc_spi_master.sv ***
// Purpose: Mode 0 link master driving frames into the flash block
// Assumes: mclk 4 ns, link clock 160 ns made from mclk counts
// Notes:   so taken as pulled up when not driven
`timescale 1ns/100ps
module sfc_spi_master (
   input  wire logic mclk,
   output logic      select_n,
   output logic      sck,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   initial begin
      select_n = 1'b1;
      sck      = 1'b0;
      si       = 1'b1;
   end

   task automatic xfer(input logic [63:0] tx, input int nb, output logic [7:0] rx, output logic oe);
      rx = 8'h00;
      oe = 1'b0;
      @(posedge mclk) select_n <= 1'b0;
      repeat (20) @(posedge mclk);
      for (int i = 0; i < nb * 8; i++) begin
         si <= tx[63-i];
         repeat (20) @(posedge mclk);
         sck <= 1'b1;
         rx = {rx[6:0], so_oe ? so : 1'b1};
         oe = oe | so_oe;
         repeat (20) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (20) @(posedge mclk);
      select_n <= 1'b1;
      si       <= ~si;
      repeat (20) @(posedge mclk);
   endtask : xfer
endmodule : sfc_spi_master

// *** dv/testbench.sv ***
// Purpose: Directed frames against the command and status block
// Assumes: Busy counts shortened to 40 cycles
// Notes:   Start pulses counted for refusal checks
`timescale 1ns/100ps
module testbench;
   logic mclk = 1'b0, rst = 1'b1, guard_pin_n = 1'b1;
   logic select_n, sck, si, so, so_oe, op_start, prog_vld, oe;
   logic [2:0]  op_kind;
   logic [15:0] op_addr;
   logic [7:0]  prog_data, status_byte, rx;
   int errors = 0, tests_run = 0, starts = 0, vlds = 0;

   always #2 mclk = ~mclk;
   always @(posedge mclk) if (op_start === 1'b1) starts++;
   always @(posedge mclk) if (prog_vld === 1'b1) vlds++;

   sfc_spi_master m (.mclk(mclk), .select_n(select_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
   sfc_flash_cmd #(.PP_CYCLES(40), .PE_CYCLES(40), .SE_CYCLES(40), .BE_CYCLES(40), .STORE_CYCLES(40))
   DUT (.mclk(mclk), .rst(rst), .select_n(select_n), .sck(sck), .si(si), .guard_pin_n(guard_pin_n),
        .so(so), .so_oe(so_oe), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
        .prog_data(prog_data), .prog_vld(prog_vld), .status_byte(status_byte));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cmd(input logic [31:0] tx, input int nb);
      m.xfer({tx, 32'h00000000}, nb, rx, oe);
   endtask : cmd

   task automatic results;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // Watchdog
   initial begin
      #200us;
      errors++;
      results();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (5) @(posedge mclk);
      chk(status_byte, 8'h00);
      cmd(32'h01fc0000, 2);
      chk(status_byte, 8'h00);
      cmd(32'h06000000, 1);
      chk(oe, 1'b0);
      chk(status_byte, 8'h02);
      cmd(32'h05000000, 2);
      chk(rx, 8'h02);
      cmd(32'h05000000, 3);
      chk(rx, 8'h02);
      cmd(32'h04000000, 1);
      chk(status_byte, 8'h00);
      cmd(32'h06000000, 1);
      cmd(32'h01fc0000, 2);
      chk(status_byte, 8'h8f);
      repeat (40) @(posedge mclk);
      chk(status_byte, 8'h8c);
      guard_pin_n <= 1'b0;
      cmd(32'h06000000, 1);
      cmd(32'h01000000, 2);
      repeat (60) @(posedge mclk);
      chk(status_byte, 8'h8e);
      cmd(32'h81000000, 4);
      chk(starts, 1);
      guard_pin_n <= 1'b1;
      cmd(32'h01000000, 2);
      repeat (60) @(posedge mclk);
      chk(status_byte, 8'h00);
      cmd(32'h06000000, 1);
      cmd(32'h81001234, 4);
      chk(status_byte, 8'h03);
      chk({op_kind, op_addr}, {3'h1, 16'h1234});
      repeat (60) @(posedge mclk);
      cmd(32'hff000000, 2);
      chk(oe, 1'b0);
      chk(starts, 3);
      cmd(32'h06000000, 1);
      m.xfer(64'h02001234a5000000, 5, rx, oe);
      chk(prog_data, 8'ha5);
      chk(vlds, 1);
      chk({op_kind, op_addr}, {3'h0, 16'h1234});
      repeat (60) @(posedge mclk);
      cmd(32'hb9000000, 1);
      cmd(32'h06000000, 1);
      chk(status_byte, 8'h00);
      cmd(32'hab000000, 4);
      cmd(32'h06000000, 1);
      chk(status_byte, 8'h02);
      results();
   end
endmodule : testbench
